// ---- rtl/acc_pkg.sv ----
// Purpose: Shared constants for the converter calibration control block
// Assumes: 8-bit special-function register bus, 12-bit converter results
// Notes:   Offsets, field positions, reset values and codes live here only
package acc_pkg;

  localparam int          ACC_DATA_W       = 8;
  localparam int          ACC_RES_W        = 12;
  localparam logic [7:0]  ACC_CAL_ADDR     = 8'hf5;
  localparam logic [7:0]  ACC_CAL_RESET    = 8'h00;

  // Field positions of the calibration control register
  localparam int          ACC_BUSY_BIT     = 7;
  localparam int          ACC_GNCL_BIT     = 6;
  localparam int          ACC_AVG_HI       = 5;
  localparam int          ACC_AVG_LO       = 4;
  localparam int          ACC_RSV3_BIT     = 3;
  localparam int          ACC_RSV2_BIT     = 2;
  localparam int          ACC_TYPE_BIT     = 1;
  localparam int          ACC_START_BIT    = 0;

  // Averaging select codes and reading counts
  localparam logic [1:0]  ACC_AVG_SEL_15   = 2'h0;
  localparam logic [1:0]  ACC_AVG_SEL_1    = 2'h1;
  localparam logic [1:0]  ACC_AVG_SEL_31   = 2'h2;
  localparam logic [1:0]  ACC_AVG_SEL_63   = 2'h3;
  localparam logic [6:0]  ACC_AVG_N_15     = 7'h0f;
  localparam logic [6:0]  ACC_AVG_N_1      = 7'h01;
  localparam logic [6:0]  ACC_AVG_N_31     = 7'h1f;
  localparam logic [6:0]  ACC_AVG_N_63     = 7'h3f;

  // Upper channel-select codes
  localparam logic [3:0]  ACC_CH_GROUND    = 4'hb;
  localparam logic [3:0]  ACC_CH_VREF      = 4'hc;
  localparam logic [3:0]  ACC_CH_DMA_STOP  = 4'hf;
  localparam logic [3:0]  ACC_CH_RSV_D     = 4'hd;
  localparam logic [3:0]  ACC_CH_RSV_E     = 4'he;

  // Ideal full-scale reading used as the gain target
  localparam logic [11:0] ACC_FULL_SCALE   = 12'hfff;
  localparam logic [11:0] ACC_GAIN_RESET   = 12'h000;
  localparam logic [11:0] ACC_OFFS_RESET   = 12'h000;

  typedef enum logic [1:0] {
    ACC_IDLE = 2'b00,
    ACC_REQ  = 2'b01,
    ACC_WAIT = 2'b11,
    ACC_DONE = 2'b10
  } acc_state_type;

endpackage

// ---- rtl/acc_avg.sv ----
// Purpose: Accumulate a set of converter readings and return their mean
// Assumes: Readings arrive one per valid pulse on the system clock
// Notes:   Divides by the exact count input with a general combinational divide
`timescale 1ns/1ps
module acc_avg #(
  parameter int RES_W = 12
) (
  input  wire logic             clk_sys,
  input  wire logic             sys_rst,
  input  wire logic             clear,
  input  wire logic             sample_vld,
  input  wire logic [RES_W-1:0] sample,
  input  wire logic [6:0]       count,
  output logic [RES_W-1:0]      mean
);
  import acc_pkg::*;

  logic [RES_W+5:0] sum_r;

  // Sum width assumes at most 63 readings; narrower results make no sense
  if (RES_W < 4 || RES_W > 24) begin : g_bad_res_w
    $error("acc_avg: RES_W out of range");
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst || clear) begin
      sum_r <= '0;
    end else if (sample_vld) begin
      sum_r <= sum_r + {6'h00, sample};
    end
  end

  // Count is never zero; caller guarantees one of the four codes
  always_comb begin
    mean = RES_W'(sum_r / {{(RES_W-1){1'b0}}, count});
  end

endmodule

// ---- rtl/acc_cal_ctrl.sv ----
// Purpose: Calibration control register and calibration sequencer
// Assumes: Core writes/reads the register on its own SFR port, one clock
// Notes:   Converter handshake is req/done; corrections go to the datapath
`timescale 1ns/1ps

// What this block does
// - Code 1011 routes analog ground, 1100 the reference; 1101 and 1110 reserved.
// - All-ones channel code fetched by capture ends the capture sequence.
// - Control register at F5H, resets to 00H, no bit access.
// - Bit 7 busy set through any conversion or calibration, self-clears.
// - Bit 6 set suppresses gain calibration; clear allows it.
// - Bits 5:4 select 15, 1, 31 or 63 averaged readings.
// - Bit 1 picks offset (0) or gain (1) calibration.
// - Writing 1 to bit 0 starts calibration; clears itself when done.
module acc_cal_ctrl (
  input  wire logic                     clk_sys,
  input  wire logic                     sys_rst,
  input  wire logic [7:0]               sfr_addr,
  input  wire logic                     sfr_wr,
  input  wire logic                     sfr_rd,
  input  wire logic [7:0]               sfr_wdata,
  output logic [7:0]                    sfr_rdata,
  output logic                          sfr_sel,
  input  wire logic [3:0]               chan_sel,
  output logic                          route_ground,
  output logic                          route_vref,
  output logic                          chan_reserved,
  input  wire logic                     dma_fetch_vld,
  input  wire logic [3:0]               dma_fetch_chan,
  output logic                          dma_stop,
  input  wire logic                     conv_active,
  output logic                          cal_conv_req,
  input  wire logic                     conv_done,
  input  wire logic [acc_pkg::ACC_RES_W-1:0] conv_result,
  output logic [acc_pkg::ACC_RES_W-1:0] offset_corr,
  output logic [acc_pkg::ACC_RES_W-1:0] gain_corr,
  output logic                          cal_busy
);
  import acc_pkg::*;

  logic                 gain_cal_disable_r;
  logic [1:0]           cal_average_count_select_r;
  logic                 rsv3_r;
  logic                 rsv2_r;
  logic                 cal_type_r;
  logic                 cal_cycle_start_r;
  acc_state_type        state_r;
  acc_state_type        state_nxt;
  logic [6:0]           reads_r;
  logic [6:0]           avg_n;
  logic                 run_type_r;
  logic                 acc_clear;
  logic                 acc_vld;
  logic [ACC_RES_W-1:0] mean;
  logic [ACC_RES_W-1:0] offset_corr_r;
  logic [ACC_RES_W-1:0] gain_corr_r;
  logic [7:0]           rdata_r;
  logic                 wr_hit;
  logic                 start_req;
  logic                 suppressed;
  logic                 dma_stop_r;

  // ---------------------------------------------------------------
  // Register access
  // ---------------------------------------------------------------
  assign sfr_sel = (sfr_addr == ACC_CAL_ADDR);
  assign wr_hit  = sfr_wr && sfr_sel;

  // Whole-byte writes only; busy is not writable
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      gain_cal_disable_r         <= ACC_CAL_RESET[ACC_GNCL_BIT];
      cal_average_count_select_r <= ACC_CAL_RESET[ACC_AVG_HI:ACC_AVG_LO];
      rsv3_r                     <= ACC_CAL_RESET[ACC_RSV3_BIT];
      rsv2_r                     <= ACC_CAL_RESET[ACC_RSV2_BIT];
      cal_type_r                 <= ACC_CAL_RESET[ACC_TYPE_BIT];
    end else if (wr_hit) begin
      gain_cal_disable_r         <= sfr_wdata[ACC_GNCL_BIT];
      cal_average_count_select_r <= sfr_wdata[ACC_AVG_HI:ACC_AVG_LO];
      // Stored as written; software is expected to keep 0 here
      rsv3_r                     <= sfr_wdata[ACC_RSV3_BIT];
      // Accepted as written; a start with this bit low still runs
      rsv2_r                     <= sfr_wdata[ACC_RSV2_BIT];
      cal_type_r                 <= sfr_wdata[ACC_TYPE_BIT];
    end
  end

  // Start bit: a write of 1 while idle starts a cycle. Completion clears
  // it; completion and a new write of 1 cannot coincide since a write
  // during a running cycle is ignored for this bit.
  assign start_req = wr_hit && sfr_wdata[ACC_START_BIT] &&
                     (state_r == ACC_IDLE);

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cal_cycle_start_r <= ACC_CAL_RESET[ACC_START_BIT];
    end else if (start_req) begin
      cal_cycle_start_r <= 1'b1;
    end else if (state_r == ACC_DONE) begin
      cal_cycle_start_r <= 1'b0;
    end
  end

  assign cal_busy = (state_r != ACC_IDLE) || conv_active;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rdata_r <= ACC_CAL_RESET;
    end else if (sfr_rd && sfr_sel) begin
      rdata_r <= {cal_busy, gain_cal_disable_r, cal_average_count_select_r,
                  rsv3_r, rsv2_r, cal_type_r, cal_cycle_start_r};
    end
  end
  assign sfr_rdata = rdata_r;

  // ---------------------------------------------------------------
  // Channel code decode
  // ---------------------------------------------------------------
  assign route_ground  = (chan_sel == ACC_CH_GROUND);
  assign route_vref    = (chan_sel == ACC_CH_VREF);
  assign chan_reserved = (chan_sel == ACC_CH_RSV_D) ||
                         (chan_sel == ACC_CH_RSV_E);

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      dma_stop_r <= 1'b0;
    end else begin
      dma_stop_r <= dma_fetch_vld && (dma_fetch_chan == ACC_CH_DMA_STOP);
    end
  end
  assign dma_stop = dma_stop_r;

  // ---------------------------------------------------------------
  // Calibration sequencer
  // ---------------------------------------------------------------
  // Count follows the stored select live; rewriting the select during a
  // run changes where that run stops, so software should not do that
  always_comb begin
    unique case (cal_average_count_select_r)
      ACC_AVG_SEL_15: avg_n = ACC_AVG_N_15;
      ACC_AVG_SEL_1:  avg_n = ACC_AVG_N_1;
      ACC_AVG_SEL_31: avg_n = ACC_AVG_N_31;
      ACC_AVG_SEL_63: avg_n = ACC_AVG_N_63;
    endcase
  end

  // A gain run with gain calibration disabled ends at once, no readings.
  // The disable bit is taken from the start write itself, so a single
  // write can both set the disable and request the suppressed run.
  assign suppressed = sfr_wdata[ACC_TYPE_BIT] &&
                      sfr_wdata[ACC_GNCL_BIT];

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ACC_IDLE: if (start_req) state_nxt = suppressed ? ACC_DONE : ACC_REQ;
      ACC_REQ:  state_nxt = ACC_WAIT;
      ACC_WAIT: if (conv_done) begin
        state_nxt = (reads_r == avg_n - 7'h01) ? ACC_DONE : ACC_REQ;
      end
      ACC_DONE: state_nxt = ACC_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_r <= ACC_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Readings are counted as they complete; comparing against count minus
  // one lets the last done step straight into DONE
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      reads_r    <= 7'h00;
      run_type_r <= 1'b0;
    end else if (start_req) begin
      reads_r    <= 7'h00;
      run_type_r <= sfr_wdata[ACC_TYPE_BIT];
    end else if (state_r == ACC_WAIT && conv_done) begin
      reads_r    <= reads_r + 7'h01;
    end
  end

  assign cal_conv_req = (state_r == ACC_REQ);
  assign acc_clear    = start_req;
  assign acc_vld      = (state_r == ACC_WAIT) && conv_done;

  acc_avg #(
    .RES_W (ACC_RES_W)
  ) u_avg (
    .clk_sys    (clk_sys),
    .sys_rst    (sys_rst),
    .clear      (acc_clear),
    .sample_vld (acc_vld),
    .sample     (conv_result),
    .count      (avg_n),
    .mean       (mean)
  );

  // ---------------------------------------------------------------
  // Correction store
  // ---------------------------------------------------------------
  // Offset stores the mean zero reading; gain stores the shortfall from
  // full scale, both subtracted/added by the conversion datapath
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      offset_corr_r <= ACC_OFFS_RESET;
      gain_corr_r   <= ACC_GAIN_RESET;
    end else if (state_r == ACC_DONE && reads_r != 7'h00) begin
      if (run_type_r) begin
        gain_corr_r   <= ACC_FULL_SCALE - mean;
      end else begin
        offset_corr_r <= mean;
      end
    end
  end
  assign offset_corr = offset_corr_r;
  assign gain_corr   = gain_corr_r;

endmodule

// ---- tb/acc_cal_ctrl_properties.sv ----
// Purpose: Port-level checks of the calibration control block
// Assumes: One clock domain, synchronous active-high reset
// Notes:   Bound to every acc_cal_ctrl instance
`timescale 1ns/1ps
module acc_chk (
  input wire logic       clk_sys,
  input wire logic       sys_rst,
  input wire logic [7:0] sfr_addr,
  input wire logic       sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  input wire logic       sfr_sel,
  input wire logic [3:0] chan_sel,
  input wire logic       route_ground,
  input wire logic       route_vref,
  input wire logic       chan_reserved,
  input wire logic       dma_fetch_vld,
  input wire logic [3:0] dma_fetch_chan,
  input wire logic       dma_stop,
  input wire logic       conv_active,
  input wire logic       cal_conv_req,
  input wire logic       cal_busy
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  property p_gnd; route_ground == (chan_sel == 4'hb); endproperty
  a_gnd: assert property (p_gnd) else $error("ground route wrong");
  property p_vref; route_vref == (chan_sel == 4'hc); endproperty
  a_vref: assert property (p_vref) else $error("vref route wrong");
  property p_rsv; chan_reserved == (chan_sel inside {4'hd, 4'he}); endproperty
  a_rsv: assert property (p_rsv) else $error("reserved flag wrong");
  property p_stop; dma_fetch_vld && dma_fetch_chan == 4'hf |=> dma_stop;
  endproperty
  a_stop: assert property (p_stop) else $error("stop missing");
  property p_nostop;
    dma_stop |-> $past(dma_fetch_vld) && $past(dma_fetch_chan) == 4'hf;
  endproperty
  a_nostop: assert property (p_nostop) else $error("stray stop");
  property p_sel; sfr_sel == (sfr_addr == 8'hf5); endproperty
  a_sel: assert property (p_sel) else $error("address match wrong");
  property p_rst; $past(sys_rst) |-> sfr_rdata == 8'h00 && !cal_conv_req;
  endproperty
  a_rst: assert property (p_rst) else $error("not cleared by reset");
  property p_start; sfr_wr && sfr_sel && sfr_wdata[0] && !cal_busy &&
    !(sfr_wdata[1] && sfr_wdata[6]) |=> cal_busy [*2]; endproperty
  a_start: assert property (p_start) else $error("start ignored");
  property p_supp; sfr_wr && sfr_sel && sfr_wdata[0] && !cal_busy &&
    sfr_wdata[1] && sfr_wdata[6] |=> !cal_conv_req ##1
    !cal_conv_req && cal_busy == conv_active; endproperty
  a_supp: assert property (p_supp) else $error("suppressed run ran");
  property p_act; conv_active |-> cal_busy; endproperty
  a_act: assert property (p_act) else $error("busy low in conversion");
  property p_req; cal_conv_req |-> cal_busy ##1 !cal_conv_req; endproperty
  a_req: assert property (p_req) else $error("request too long");
endmodule
bind acc_cal_ctrl acc_chk u_chk (.clk_sys, .sys_rst, .sfr_addr, .sfr_wr,
  .sfr_wdata, .sfr_rdata, .sfr_sel, .chan_sel, .route_ground, .route_vref,
  .chan_reserved, .dma_fetch_vld, .dma_fetch_chan, .dma_stop, .conv_active,
  .cal_conv_req, .cal_busy);

// ---- tb/tb.sv ----
// Purpose: Directed bench for the calibration control block
// Assumes: Inputs change at the falling edge; register reads take a cycle
// Notes:   Converter stand-in answers each reading one cycle late
`timescale 1ns/1ps
module tb;
  import acc_pkg::*;
  logic        clk_sys = 0, sys_rst = 1, sfr_wr = 0, sfr_rd = 0;
  logic        conv_active = 0, dma_fetch_vld = 0, conv_done = 0, req_d = 0;
  logic [7:0]  sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata, d;
  logic [3:0]  chan_sel = 4'h0, dma_fetch_chan = 4'h0;
  logic [11:0] cbase = 12'h000, conv_result, offset_corr, gain_corr;
  logic        sfr_sel, route_ground, route_vref, chan_reserved, dma_stop;
  logic        cal_conv_req, cal_busy;
  int          fail_count = 0, checked = 0, cycles = 0, nreq = 0;
  int          nbase = 0, nrun = 0;
  int          n_tab[4] = '{15, 1, 31, 63};
  always #10 clk_sys = ~clk_sys;
  acc_cal_ctrl DUT (.clk_sys, .sys_rst, .sfr_addr, .sfr_wr, .sfr_rd,
    .sfr_wdata, .sfr_rdata, .sfr_sel, .chan_sel, .route_ground, .route_vref,
    .chan_reserved, .dma_fetch_vld, .dma_fetch_chan, .dma_stop, .conv_active,
    .cal_conv_req, .conv_done, .conv_result, .offset_corr, .gain_corr,
    .cal_busy);
  // Readings alternate one above and one below the base, so the mean
  // differs from the last reading whenever more than one reading is taken
  assign conv_result = (nreq[0] ^ nbase[0]) ? cbase + 12'h001
                                            : cbase - 12'h001;
  always @(negedge clk_sys) begin
    req_d <= cal_conv_req;
    conv_done <= req_d;
    if (cal_conv_req) nreq <= nreq + 1;
  end
  // The whole bench takes a few hundred cycles; the ceiling leaves wide margin
  always @(posedge clk_sys) cycles <= cycles + 1;
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk_sys);
    sfr_addr = a;
    sfr_wdata = v;
    sfr_wr = 1;
    @(negedge clk_sys);
    sfr_wr = 0;
  endtask
  task automatic rd();
    @(negedge clk_sys);
    sfr_addr = ACC_CAL_ADDR;
    sfr_rd = 1;
    @(negedge clk_sys);
    sfr_rd = 0;
    d = sfr_rdata;
  endtask
  // Start a run, then poll until the start bit drops
  task automatic cal(input logic [7:0] v, input logic bsy);
    nbase = nreq;
    wr(ACC_CAL_ADDR, v);
    for (int i = 0; i < 200; i++) begin
      rd();
      if (i == 0 && bsy) chk(12'(d[7]), 12'h001);
      if (d[0] === 1'b0) break;
    end
    chk(12'(d), 12'(v & 8'h7e));
    nrun = nreq - nbase;
  endtask
  task automatic print_verdict();
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic run_tests();
    repeat (16) @(posedge clk_sys);
    @(negedge clk_sys);
    sys_rst = 0;
    rd();
    chk(12'(d), 12'(ACC_CAL_RESET));
    wr(8'hf4, 8'h34);
    rd();
    chk(12'(d), 12'h000);
    chk(12'(sfr_sel), 12'h001);
    wr(ACC_CAL_ADDR, 8'h80);
    rd();
    chk(12'(d), 12'h000);
    conv_active = 1;
    rd();
    chk(12'(d[7]), 12'h001);
    conv_active = 0;
    rd();
    chk(12'(d[7]), 12'h000);
    $display("register test done");
    for (int a = 0; a < 4; a++) begin
      cbase = 12'h100 + 12'(a);
      cal(8'h05 | 8'(a << 4), 1'b1);
      chk(12'(nrun), 12'(n_tab[a]));
      // A single reading is base plus one; odd counts above one average
      // to the base itself
      chk(offset_corr, cbase + 12'(a == 1));
    end
    cbase = 12'hf00;
    cal(8'h07, 1'b1);
    chk(gain_corr, 12'h0ff);
    chk(offset_corr, 12'h103);
    cbase = 12'he00;
    cal(8'h47, 1'b0);
    chk(12'(nrun), 12'h000);
    chk(gain_corr, 12'h0ff);
    $display("calibration test done");
    for (int c = 0; c < 16; c++) begin
      @(negedge clk_sys);
      chan_sel = 4'(c);
      dma_fetch_chan = 4'(c);
      dma_fetch_vld = 1;
      #1 chk(12'({route_ground, route_vref, chan_reserved}),
        12'({c == 11, c == 12, c == 13 || c == 14}));
      @(negedge clk_sys);
      dma_fetch_vld = 0;
      chk(12'(dma_stop), 12'(c == 15));
    end
    $display("channel test done");
  endtask
  initial begin
    fork
      run_tests();
      begin
        wait (cycles == 3000);
        fail_count++;
        $display("ERROR %0t: timeout", $time);
      end
    join_any
    print_verdict();
  end
endmodule
